// file: spc_run_ctrl.sv
// run control of a sampler: flow pacing, level hold-off and paired operation
// ****************************************
// Functional notes
// - level not touching probe keeps sampling inhibited
// - latch mode keeps running after liquid recedes
// - follow mode halts when liquid leaves sensor
// - level hold-off obeyed only when enabled
// - both units need paired mode enabled
// - running master drives hold-off on shared line
// - slave stays dormant until master finishes
// - paired mode replaces bottle index with hold-off
// - paired mode line holds constant, no index
// - first unit started becomes the master
// - roles swap only while both in run
// ****************************************
`timescale 1ns/1ps
module spc_run_ctrl #(
    parameter logic [spc_pkg::FLOW_CNT_W-1:0] FLOW_MIN_CYCLES = spc_pkg::FLOW_MIN_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // connector pins
    input wire logic flow_pin,
    input wire logic holdoff_pin,
    output logic shared_out,
    output logic event_out,
    // configuration
    input wire logic level_respond,
    input wire logic level_latch,
    input wire logic pair_mode,
    // sampler engine
    input wire logic run_request,
    input wire logic routine_done,
    input wire logic event_req,
    input wire logic [spc_pkg::BOT_W-1:0] bottle_index,
    // status
    output logic sampling_on,
    output logic master_role,
    output logic dormant,
    output logic flow_pulse_out,
    output logic [spc_pkg::FLOW_TOT_W-1:0] flow_total,
    output spc_pkg::spc_state_t state_out
);
    import spc_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    spc_bot_if bot ();             // link to the bottle transmitter
    spc_state_t state;             // run control state
    spc_state_t next_state;        // next run control state
    logic flow_pulse;              // one qualified flow closure
    logic holdoff_s;               // synchronised hold-off input
    logic level_block;             // level says do not sample
    logic partner_block;           // partner master says stay dormant
    logic next_master;             // next master role

    // ****************************************
    // input qualification
    // ****************************************
    spc_flow_qual u_qual (
        .clk_sys (clk_sys),
        .rst_n (rst_n),
        .min_cyc (FLOW_MIN_CYCLES),
        .flow_raw (flow_pin),
        .holdoff_raw (holdoff_pin),
        .flow_pulse (flow_pulse),
        .holdoff_s (holdoff_s)
    );

    // ****************************************
    // bottle index transmitter
    // ****************************************
    spc_bottle_tx u_tx (
        .clk_sys (clk_sys),
        .rst_n (rst_n),
        .bot (bot)
    );

    // index goes out only when the line is not lent to paired mode
    assign bot.start = event_req && !pair_mode;
    assign bot.index = bottle_index;

    // ****************************************
    // hold-off interpretation
    // ****************************************
    // outside paired mode the input is the level actuator alone, and then only when enabled
    assign level_block = !pair_mode && level_respond && holdoff_s;
    // in paired mode the input is the partner's hold-off
    assign partner_block = pair_mode && holdoff_s;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_state = state;
        next_master = master_role;
        case (state)
            SPC_IDLE: begin
                if (run_request) begin
                    // partner already running: we become its slave
                    if (partner_block || level_block) begin
                        next_state = SPC_HOLD;
                        next_master = 1'b0;
                    end else begin
                        next_state = SPC_RUN;
                        next_master = pair_mode;
                    end
                end
            end
            SPC_HOLD: begin
                // partner released its hold-off while we are in run: swap
                if (!partner_block && !level_block) begin
                    next_state = SPC_RUN;
                    next_master = pair_mode;
                end
            end
            SPC_RUN: begin
                if (routine_done) begin
                    // finished master leaves the run state until restarted
                    next_state = SPC_IDLE;
                    next_master = 1'b0;
                end else if (level_block && !level_latch) begin
                    next_state = SPC_HOLD;
                end
                // in latch mode the receding level is ignored here
            end
            default: begin
                next_state = SPC_IDLE;
                next_master = 1'b0;
            end
        endcase
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= SPC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // role register
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            master_role <= 1'b0;
        end else begin
            master_role <= next_master;
        end
    end

    // ****************************************
    // status outputs
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sampling_on <= 1'b0;
            dormant <= 1'b0;
            state_out <= SPC_IDLE;
        end else begin
            sampling_on <= (next_state == SPC_RUN);
            dormant <= (next_state == SPC_HOLD) && pair_mode;
            state_out <= next_state;
        end
    end

    // ****************************************
    // shared line and event mark
    // ****************************************
    // paired mode: steady hold-off while running as master, else the pulse train
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shared_out <= 1'b0;
            event_out <= 1'b0;
        end else begin
            if (pair_mode) begin
                shared_out <= (next_state == SPC_RUN);
            end else begin
                shared_out <= bot.line;
            end
            event_out <= event_req;
        end
    end

    // ****************************************
    // flow pulse count
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flow_pulse_out <= 1'b0;
            flow_total <= FLOW_TOT_RST;
        end else begin
            flow_pulse_out <= flow_pulse;
            if (flow_pulse) begin
                flow_total <= flow_total + 1'b1;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_slave_waiting;
        state == SPC_HOLD && partner_block;
    endsequence
    sequence s_partner_release;
        state == SPC_HOLD && !holdoff_s && pair_mode && !level_block;
    endsequence

    property p_level_inhibits;
        level_block && state != SPC_RUN |=> !sampling_on;
    endproperty
    a_level_inhibits: assert property (p_level_inhibits)
        else $error("sampling began while level inhibits");

    property p_latch_keeps;
        state == SPC_RUN && level_latch && level_block && !routine_done |=> state == SPC_RUN;
    endproperty
    a_latch_keeps: assert property (p_latch_keeps)
        else $error("latch mode stopped on receding level");

    property p_follow_halts;
        state == SPC_RUN && !level_latch && level_block && !routine_done
            |=> state == SPC_HOLD ##0 !sampling_on;
    endproperty
    a_follow_halts: assert property (p_follow_halts)
        else $error("follow mode did not halt");

    // enable dropped while held: release on the next edge
    property p_level_ignored;
        state == SPC_HOLD && !pair_mode && !level_respond |=> state == SPC_RUN;
    endproperty
    a_level_ignored: assert property (p_level_ignored)
        else $error("hold-off obeyed while not enabled");

    // a master that finishes this cycle drops the line with the state
    property p_master_line;
        pair_mode && state == SPC_RUN && $stable(pair_mode) && !routine_done |=> shared_out;
    endproperty
    a_master_line: assert property (p_master_line)
        else $error("master not driving hold-off");

    property p_slave_dormant;
        s_slave_waiting |=> dormant && !sampling_on && state == SPC_HOLD;
    endproperty
    a_slave_dormant: assert property (p_slave_dormant)
        else $error("slave left dormancy under hold-off");

    property p_swap;
        s_partner_release |=> state == SPC_RUN ##0 master_role;
    endproperty
    a_swap: assert property (p_swap)
        else $error("roles did not swap on release");

    property p_no_index;
        pair_mode [*3] |-> !bot.busy || shared_out == (state == SPC_RUN) || $past(state) != state;
    endproperty
    a_no_index: assert property (p_no_index)
        else $error("bottle index on line in paired mode");

    property p_first_master;
        state == SPC_IDLE && run_request && pair_mode && !holdoff_s |=> master_role;
    endproperty
    a_first_master: assert property (p_first_master)
        else $error("first unit started is not master");

    // the line drops in the same cycle as the state; a restart may follow at once
    property p_done_stops;
        state == SPC_RUN && routine_done
            |=> state == SPC_IDLE && (!shared_out || !pair_mode);
    endproperty
    a_done_stops: assert property (p_done_stops)
        else $error("finished unit did not leave run");

    property p_one_count;
        flow_pulse_out |=> !flow_pulse_out;
    endproperty
    a_one_count: assert property (p_one_count)
        else $error("more than one count per closure");

    // paired mode never starts a bottle train on the shared line
    property p_no_train;
        pair_mode && !bot.busy |=> !bot.busy;
    endproperty
    a_no_train: assert property (p_no_train)
        else $error("bottle train started in paired mode");

    // paired line only moves with the run state, never like an index
    property p_line_steady;
        pair_mode [*3] ##0 $stable(state) |-> $stable(shared_out);
    endproperty
    a_line_steady: assert property (p_line_steady)
        else $error("paired line changed without a state change");
endmodule

// file: spc_pkg.sv
// package of constants and types for the sampler pacing control
package spc_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam longint CLK_HZ = 200_000_000;   // system clock rate
    localparam longint FLOW_MIN_MS = 25;       // least flow contact closure, ms
    // least closure in cycles, rounded up
    localparam longint FLOW_MIN_CYC_L = (FLOW_MIN_MS * CLK_HZ + 999) / 1000;
    localparam int FLOW_CNT_W = 23;            // holds the closure count
    localparam logic [FLOW_CNT_W-1:0] FLOW_MIN_CYC = FLOW_CNT_W'(FLOW_MIN_CYC_L);
    localparam int BOT_PULSE_CYC = 8;          // half period of one bottle pulse
    localparam int BOT_W = 4;                  // bottle index width
    localparam int FLOW_TOT_W = 16;            // flow pulse total width
    // ****************************************
    // reset values
    // ****************************************
    localparam logic [FLOW_TOT_W-1:0] FLOW_TOT_RST = 16'h0000;
    // ****************************************
    // run control states, one-hot
    // ****************************************
    typedef enum logic [3:0] {
        SPC_IDLE = 4'h1,   // not in the run state
        SPC_HOLD = 4'h2,   // run state, inhibited by level or partner
        SPC_RUN = 4'h4,    // executing the routine
        SPC_SPARE = 4'h8   // unused code, falls back to idle
    } spc_state_t;
endpackage

// file: spc_bot_if.sv
// interface between run control and the bottle pulse transmitter
`timescale 1ns/1ps
interface spc_bot_if;
    logic start;                       // one-cycle request to send an index
    logic [spc_pkg::BOT_W-1:0] index;  // bottle index to send
    logic busy;                        // a pulse train is in progress
    logic line;                        // bottle pulse line level
    // transmitter side
    modport tx (input start, input index, output busy, output line);
    // controller side
    modport ctl (output start, output index, input busy, input line);
endinterface

// file: spc_flow_qual.sv
// synchroniser for the flow closure and hold-off inputs, minimum-width qualifier for the flow closure only
`timescale 1ns/1ps
module spc_flow_qual (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // settings
    input wire logic [spc_pkg::FLOW_CNT_W-1:0] min_cyc,
    // raw pins
    input wire logic flow_raw,
    input wire logic holdoff_raw,
    // qualified results
    output logic flow_pulse,
    output logic holdoff_s
);
    import spc_pkg::*;
    logic [1:0] flow_sync;                 // two-stage flow synchroniser
    logic [1:0] hold_sync;                 // two-stage hold-off synchroniser
    logic [FLOW_CNT_W-1:0] width_cnt;      // cycles of the current closure

    // ****************************************
    // synchronisers
    // ****************************************
    // both pins pass two flip-flops before any logic reads them
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flow_sync <= 2'h0;
            hold_sync <= 2'h0;
        end else begin
            flow_sync <= {flow_sync[0], flow_raw};
            hold_sync <= {hold_sync[0], holdoff_raw};
        end
    end
    assign holdoff_s = hold_sync[1];

    // ****************************************
    // closure width counter
    // ****************************************
    // counts while closed, saturates at the limit so it fires once
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            width_cnt <= '0;
            flow_pulse <= 1'b0;
        end else begin
            flow_pulse <= 1'b0;
            if (!flow_sync[1]) begin
                width_cnt <= '0;
            end else if (width_cnt < min_cyc) begin
                width_cnt <= width_cnt + 1'b1;
                // one pulse when the width is first reached
                flow_pulse <= (width_cnt + 1'b1 == min_cyc);
            end
        end
    end
endmodule

// file: spc_bottle_tx.sv
// bottle index pulse train transmitter for the shared output line
`timescale 1ns/1ps
module spc_bottle_tx (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // controller side
    spc_bot_if.tx bot
);
    import spc_pkg::*;
    logic [BOT_W-1:0] left;      // pulses still to send
    logic [3:0] phase_cnt;       // cycles in the current half period
    logic tick;                  // end of a half period

    assign tick = (phase_cnt == 4'(BOT_PULSE_CYC - 1));

    // ****************************************
    // half period divider
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            phase_cnt <= 4'h0;
        end else if (!bot.busy || tick) begin
            phase_cnt <= 4'h0;
        end else begin
            phase_cnt <= phase_cnt + 4'h1;
        end
    end

    // ****************************************
    // pulse train, one high half and one low half per count
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            left <= '0;
            bot.busy <= 1'b0;
            bot.line <= 1'b0;
        end else if (!bot.busy) begin
            // index zero sends nothing
            if (bot.start && bot.index != '0) begin
                left <= bot.index;
                bot.busy <= 1'b1;
                bot.line <= 1'b1;
            end
        end else if (tick) begin
            if (bot.line) begin
                bot.line <= 1'b0;
                left <= left - 1'b1;
            end else if (left == '0) begin
                bot.busy <= 1'b0;
            end else begin
                bot.line <= 1'b1;
            end
        end
    end
endmodule

// file: spc_partner.sv
// far-side model: partner sampler, flow meter contact and level actuator
`timescale 1ns/1ps
module spc_partner (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pins facing the sampler
    input wire logic peer_in,
    output logic holdoff_out,
    output logic flow_out,
    // partner setup and operator keys
    input wire logic pair_mode,
    input wire logic level_dry,
    input wire logic start,
    input wire logic done
);
    logic running;  // partner executes its routine
    logic waiting;  // partner started while the unit held the line
    // partner run control, same role scheme as the unit under test
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            running <= 1'b0;
            waiting <= 1'b0;
        end else if (start && pair_mode) begin
            running <= !peer_in;
            waiting <= peer_in;
        end else if (waiting && !peer_in) begin
            running <= 1'b1;
            waiting <= 1'b0;
        end else if (done) begin
            running <= 1'b0;
        end
    end
    // paired: hold-off while running; otherwise the probe, high when dry
    assign holdoff_out = pair_mode ? running : level_dry;
    // flow contact held for len cycles, then opened for gap cycles
    initial flow_out = 1'b0;
    task automatic closure(input int len, input int gap);
        flow_out = 1'b1;
        repeat (len) @(posedge clk_sys);
        #1 flow_out = 1'b0;
        repeat (gap) @(posedge clk_sys);
        #1;
    endtask
endmodule

// file: test_sampler_pair_pacing_control.sv
// self-checking bench for the sampler pacing control
`timescale 1ns/1ps
module test_sampler_pair_pacing_control;
    import spc_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [FLOW_CNT_W-1:0] MIN_CYC = 23'h000008;  // short closure count
    logic clk_sys, rst_n, flow_pin, holdoff_pin, shared_out, event_out;
    logic level_respond, level_latch, pair_mode, run_request, routine_done, event_req;
    logic [BOT_W-1:0] bottle_index;
    logic sampling_on, master_role, dormant, flow_pulse_out;
    logic [FLOW_TOT_W-1:0] flow_total;
    spc_state_t state_out;
    logic peer_start, peer_done, level_dry, last_shared;
    logic [15:0] lfsr;  // random source
    logic [BOT_W-1:0] idx_tab [4] = '{4'h0, 4'h1, 4'h3, 4'hf};  // bottle indices sent
    int bad_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int exp_total = 0;  // model of qualified closures
    int pulses = 0;
    int rises = 0;
    int falls = 0;
    int events = 0;
    // ****************************************
    // design and far side
    // ****************************************
    spc_run_ctrl #(.FLOW_MIN_CYCLES(MIN_CYC)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .flow_pin(flow_pin), .holdoff_pin(holdoff_pin), .shared_out(shared_out),
        .event_out(event_out), .level_respond(level_respond), .level_latch(level_latch),
        .pair_mode(pair_mode), .run_request(run_request), .routine_done(routine_done),
        .event_req(event_req), .bottle_index(bottle_index), .sampling_on(sampling_on),
        .master_role(master_role), .dormant(dormant), .flow_pulse_out(flow_pulse_out),
        .flow_total(flow_total), .state_out(state_out));
    spc_partner i_peer (.clk_sys(clk_sys), .rst_n(rst_n), .peer_in(shared_out),
        .holdoff_out(holdoff_pin), .flow_out(flow_pin), .pair_mode(pair_mode),
        .level_dry(level_dry), .start(peer_start), .done(peer_done));
    // ****************************************
    // clock, monitors and timeout
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // counts pulses and line edges, cuts a hang short
    always @(posedge clk_sys) begin
        cycles++;
        if (flow_pulse_out === 1'b1) pulses++;
        if (event_out === 1'b1) events++;
        if (shared_out === 1'b1 && last_shared === 1'b0) rises++;
        if (shared_out === 1'b0 && last_shared === 1'b1) falls++;
        last_shared = shared_out;
        if (cycles == 6000) begin
            bad_count++;
            finish_test();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(ref logic sig);
        sig = 1'b1;
        tick(1);
        sig = 1'b0;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // state and status; role outputs only mean something in paired mode
    task automatic status(input logic [3:0] st, input logic mr, input logic dm, input logic so);
        check("state_out", 16'(state_out), 16'(st));
        check("sampling_on", 16'(sampling_on), 16'(st == 4'h4));
        if (pair_mode) begin
            check("master_role", 16'(master_role), 16'(mr));
            check("dormant", 16'(dormant), 16'(dm));
            check("shared_out", 16'(shared_out), 16'(so));
        end
    endtask
    task automatic finish_test;
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int len;
        rst_n = 1'b0;
        {level_respond, level_latch, pair_mode, run_request} = 4'h0;
        {routine_done, event_req, peer_start, peer_done, level_dry} = 5'h00;
        bottle_index = 4'h0;
        last_shared = 1'b0;
        lfsr = 16'h3c86;
        tick(3);
        rst_n = 1'b1;
        tick(2);
        status(4'h1, 1'b0, 1'b0, 1'b0);
        check("flow_total", 16'(flow_total), 16'h0000);
        check("roles", 16'({master_role, dormant, shared_out, event_out}), 16'h0000);
        // random closures, short ones must not count
        for (int i = 0; i < 14; i++) begin
            lfsr = lfsr_next(lfsr);
            len = lfsr[0] ? 10 + int'(lfsr[4:1]) : 2 + int'(lfsr[2:1]);
            if (lfsr[0]) exp_total++;
            i_peer.closure(len, 3 + int'(lfsr[6:5]));
        end
        tick(14);
        check("flow_total", 16'(flow_total), 16'(exp_total));
        check("flow pulses", 16'(pulses), 16'(exp_total));
        // level hold-off in follow and latch modes
        level_respond = 1'b1;
        for (int m = 0; m < 2; m++) begin
            level_latch = m[0];
            level_dry = 1'b1;
            tick(6);
            pulse(run_request);
            tick(4);
            status(4'h2, 1'b0, 1'b0, 1'b0);
            level_dry = 1'b0;
            tick(6);
            status(4'h4, 1'b0, 1'b0, 1'b0);
            level_dry = 1'b1;
            tick(6);
            status(m ? 4'h4 : 4'h2, 1'b0, 1'b0, 1'b0);
            level_dry = 1'b0;
            tick(6);
            pulse(routine_done);
            tick(3);
            status(4'h1, 1'b0, 1'b0, 1'b0);
        end
        // probe ignored once disabled, even from hold; bottle trains meanwhile
        level_dry = 1'b1;
        tick(6);
        pulse(run_request);
        tick(2);
        status(4'h2, 1'b0, 1'b0, 1'b0);
        level_respond = 1'b0;
        tick(2);
        status(4'h4, 1'b0, 1'b0, 1'b0);
        foreach (idx_tab[i]) begin
            bottle_index = idx_tab[i];
            rises = 0;
            events = 0;
            pulse(event_req);
            tick(16 * int'(idx_tab[i]) + 12);
            check("bottle pulses", 16'(rises), 16'(idx_tab[i]));
            check("event marks", 16'(events), 16'h0001);
        end
        pulse(routine_done);
        level_dry = 1'b0;
        tick(4);
        // paired operation with a partner sampler
        pair_mode = 1'b1;
        tick(4);
        pulse(run_request);
        tick(3);
        status(4'h4, 1'b1, 1'b0, 1'b1);
        pulse(peer_start);
        tick(3);
        check("holdoff_pin", 16'(holdoff_pin), 16'h0000);
        bottle_index = 4'h5;
        falls = 0;
        pulse(event_req);
        tick(100);
        check("shared falls", 16'(falls), 16'h0000);
        pulse(routine_done);
        tick(6);
        status(4'h1, 1'b0, 1'b0, 1'b0);
        check("holdoff_pin", 16'(holdoff_pin), 16'h0001);
        pulse(run_request);
        tick(6);
        status(4'h2, 1'b0, 1'b1, 1'b0);
        pulse(peer_done);
        tick(6);
        status(4'h4, 1'b1, 1'b0, 1'b1);
        pulse(routine_done);
        tick(20);
        status(4'h1, 1'b0, 1'b0, 1'b0);
        check("holdoff_pin", 16'(holdoff_pin), 16'h0000);
        finish_test();
    end
endmodule
